//--- core/dgpg_top.sv
// Top: dual-group pulse generator with AXI4-Lite registers and interrupt
// Operation
// - Eight independent outputs from four generators
// - Optional four complementary pairs with dead zone
// - Eight-bit prescaler per generator
// - Divider of 1, 2, 4, 8, 16
// - Eight timers, 16-bit counter and comparator
// - Per-channel flag set at counter zero
// - Interrupt only when flag and enable set
// - One-shot or auto-reload per timer
// - Pair 0/1 uses timer 0, dead zone 0
// - Pairs 2/3,4/5,6/7 use timers 2,4,6
// - Buffers load into active at zero in auto-reload
// - Auto-reload reloads period and keeps counting
// - One-shot stops at zero, one request
// - Output set when counter reaches compare, cleared at reload or start
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/10ps
module dgpg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [7:0] pulse_outputs_zero_to_seven,
    output logic irq
);
    typedef struct packed {
        dgpg_pkg::dgpg_cfg_s cfg;
        logic [7:0] stat;
        logic [3:0][7:0] pre;
        logic [3:0][2:0] div;
        logic [3:0][7:0] pre_cnt;
        logic [3:0][15:0] div_cnt;
        logic [3:0] tick;
        logic [7:0][15:0] per;
        logic [7:0][15:0] cmp;
        logic [3:0][7:0] dt;
        logic [3:0][7:0] dt_a;
        logic [3:0][7:0] dt_b;
        logic [7:0] lvl_d;
        logic [7:0] outq;
        logic aw_h;
        logic w_h;
        logic [7:0] aw_a;
        logic [31:0] w_d;
        logic [3:0] w_s;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic awrdy;
        logic wrdy;
        logic arrdy;
        logic irq;
    } dgpg_top_s;

    dgpg_top_s r;
    dgpg_top_s next_r;
    logic [7:0] zp;
    logic [7:0] lvl;

    // Apply byte strobes to a register word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] s);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                m[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // Divider terminal count for a code 0..4
    function automatic logic [15:0] div_tc(input logic [2:0] code);
        logic [2:0] c;
        c = (code > dgpg_pkg::DIV_MAX) ? dgpg_pkg::DIV_MAX : code;
        return (16'h0001 << c) - 16'h0001;
    endfunction

    // Timer instances: generator g owns channels 2g and 2g+1
    for (genvar c = 0; c < dgpg_pkg::CH_N; c++) begin : g_tmr
        dgpg_timer u_tmr (
            .aclk(aclk),
            .aresetn(aresetn),
            .run(r.cfg.run[c]),
            .autoreload(r.cfg.autoreload[c]),
            .tick(r.tick[c/2]),
            .period_buf(r.per[c]),
            .cmp_buf(r.cmp[c]),
            .zero_pulse(zp[c]),
            .level(lvl[c])
        );
    end

    always_comb begin
        logic [7:0] a;
        logic [31:0] wv;
        logic [31:0] rv;
        logic wr;
        logic ok;
        logic [2:0] idx;
        logic [7:0] clr;
        a = 8'h00;
        wv = 32'h0;
        rv = 32'h0;
        wr = 1'b0;
        ok = 1'b0;
        idx = 3'h0;
        clr = 8'h00;
        next_r = r;

        // ---------------------------------------------
        // Clock prescale and divide
        // ---------------------------------------------
        for (int g = 0; g < 4; g++) begin
            next_r.tick[g] = 1'b0;
            if (r.pre_cnt[g] >= r.pre[g]) begin
                next_r.pre_cnt[g] = 8'h00;
                if (r.div_cnt[g] >= div_tc(r.div[g])) begin
                    next_r.div_cnt[g] = 16'h0000;
                    next_r.tick[g] = 1'b1;
                end else begin
                    next_r.div_cnt[g] = r.div_cnt[g] + 16'h0001;
                end
            end else begin
                next_r.pre_cnt[g] = r.pre_cnt[g] + 8'h01;
            end
        end

        // ---------------------------------------------
        // Output shaping and dead zone
        // ---------------------------------------------
        next_r.lvl_d = lvl;
        for (int g = 0; g < 4; g++) begin
            if (r.cfg.dz_en[g]) begin
                // Master timer drives both; rising edges wait out the dead time
                if (!lvl[2*g]) begin
                    next_r.dt_a[g] = 8'h00;
                end else if (r.dt_a[g] != r.dt[g]) begin
                    next_r.dt_a[g] = r.dt_a[g] + 8'h01;
                end
                if (lvl[2*g]) begin
                    next_r.dt_b[g] = 8'h00;
                end else if (r.dt_b[g] != r.dt[g]) begin
                    next_r.dt_b[g] = r.dt_b[g] + 8'h01;
                end
                next_r.outq[2*g] = lvl[2*g] && (r.dt_a[g] == r.dt[g]);
                next_r.outq[2*g+1] = !lvl[2*g] && (r.dt_b[g] == r.dt[g])
                                     && r.cfg.run[2*g];
            end else begin
                next_r.outq[2*g] = lvl[2*g];
                next_r.outq[2*g+1] = lvl[2*g+1];
            end
        end

        // ---------------------------------------------
        // AXI4-Lite slave
        // ---------------------------------------------
        if (s_axi_awvalid && !r.aw_h) begin
            next_r.aw_h = 1'b1;
            next_r.aw_a = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r.w_h) begin
            next_r.w_h = 1'b1;
            next_r.w_d = s_axi_wdata;
            next_r.w_s = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        wr = r.aw_h && r.w_h && !r.bvalid;
        if (wr) begin
            a = r.aw_a;
            ok = 1'b1;
            idx = a[4:2];
            next_r.aw_h = 1'b0;
            next_r.w_h = 1'b0;
            next_r.bvalid = 1'b1;
            if (a == dgpg_pkg::OFF_CTRL) begin
                wv = merge({24'h0, r.cfg.run}, r.w_d, r.w_s);
                next_r.cfg.run = wv[7:0];
            end else if (a == dgpg_pkg::OFF_MODE) begin
                wv = merge({24'h0, r.cfg.autoreload}, r.w_d, r.w_s);
                next_r.cfg.autoreload = wv[7:0];
            end else if (a == dgpg_pkg::OFF_DZEN) begin
                wv = merge({28'h0, r.cfg.dz_en}, r.w_d, r.w_s);
                next_r.cfg.dz_en = wv[3:0];
            end else if (a == dgpg_pkg::OFF_STAT) begin
                if (r.w_s[0]) begin
                    clr = r.w_d[7:0];
                end
            end else if (a == dgpg_pkg::OFF_MASK) begin
                wv = merge({24'h0, r.cfg.mask}, r.w_d, r.w_s);
                next_r.cfg.mask = wv[7:0];
            end else if (a == dgpg_pkg::OFF_PRE) begin
                next_r.pre = merge(r.pre, r.w_d, r.w_s);
            end else if (a == dgpg_pkg::OFF_OUT) begin
                wv = merge({20'h0, r.div}, r.w_d, r.w_s);
                next_r.div = wv[11:0];
            end else if (a[7:5] == dgpg_pkg::OFF_PER0[7:5] && a[1:0] == 2'h0) begin
                wv = merge({16'h0, r.per[idx]}, r.w_d, r.w_s);
                next_r.per[idx] = wv[15:0];
            end else if (a[7:5] == dgpg_pkg::OFF_CMP0[7:5] && a[1:0] == 2'h0) begin
                wv = merge({16'h0, r.cmp[idx]}, r.w_d, r.w_s);
                next_r.cmp[idx] = wv[15:0];
            end else if (a[7:4] == dgpg_pkg::OFF_DT0[7:4] && a[1:0] == 2'h0) begin
                wv = merge({24'h0, r.dt[idx[1:0]]}, r.w_d, r.w_s);
                next_r.dt[idx[1:0]] = wv[7:0];
            end else begin
                ok = 1'b0;
            end
            next_r.bresp = ok ? dgpg_pkg::RESP_OKAY : dgpg_pkg::RESP_SLVERR;
        end

        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        if (s_axi_arvalid && !r.rvalid) begin
            a = s_axi_araddr;
            idx = a[4:2];
            ok = 1'b1;
            if (a == dgpg_pkg::OFF_CTRL) begin
                rv = {24'h0, r.cfg.run};
            end else if (a == dgpg_pkg::OFF_MODE) begin
                rv = {24'h0, r.cfg.autoreload};
            end else if (a == dgpg_pkg::OFF_DZEN) begin
                rv = {28'h0, r.cfg.dz_en};
            end else if (a == dgpg_pkg::OFF_STAT) begin
                rv = {24'h0, r.stat};
            end else if (a == dgpg_pkg::OFF_MASK) begin
                rv = {24'h0, r.cfg.mask};
            end else if (a == dgpg_pkg::OFF_PRE) begin
                rv = r.pre;
            end else if (a == dgpg_pkg::OFF_OUT) begin
                rv = {12'h0, r.outq, r.div};
            end else if (a[7:5] == dgpg_pkg::OFF_PER0[7:5] && a[1:0] == 2'h0) begin
                rv = {16'h0, r.per[idx]};
            end else if (a[7:5] == dgpg_pkg::OFF_CMP0[7:5] && a[1:0] == 2'h0) begin
                rv = {16'h0, r.cmp[idx]};
            end else if (a[7:4] == dgpg_pkg::OFF_DT0[7:4] && a[1:0] == 2'h0) begin
                rv = {24'h0, r.dt[idx[1:0]]};
            end else begin
                ok = 1'b0;
            end
            next_r.rvalid = 1'b1;
            next_r.rdata = rv;
            next_r.rresp = ok ? dgpg_pkg::RESP_OKAY : dgpg_pkg::RESP_SLVERR;
        end

        // ---------------------------------------------
        // Interrupt flags
        // ---------------------------------------------
        // A zero in the same cycle as a clear keeps the flag set
        next_r.stat = (r.stat & ~clr) | zp;
        next_r.irq = |(next_r.stat & next_r.cfg.mask);
        // Ready flags are registered so that every bus output leaves a flop
        next_r.awrdy = !next_r.aw_h;
        next_r.wrdy = !next_r.w_h;
        next_r.arrdy = !next_r.rvalid;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
            r.per <= {8{dgpg_pkg::PER_RST}};
            r.cmp <= {8{dgpg_pkg::CMP_RST}};
            r.dt <= {4{dgpg_pkg::DT_RST}};
            r.awrdy <= 1'b1;
            r.wrdy <= 1'b1;
            r.arrdy <= 1'b1;
        end else begin
            r <= next_r;
        end
    end

    assign s_axi_awready = r.awrdy;
    assign s_axi_wready = r.wrdy;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_arready = r.arrdy;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign pulse_outputs_zero_to_seven = r.outq;
    assign irq = r.irq;

    flag_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
        zp[0] |=> r.stat[0])
        else $error("zero did not set flag");
    irq_gate_a: assert property (@(posedge aclk) disable iff (!aresetn)
        irq == (|(r.stat & r.cfg.mask)))
        else $error("interrupt without enabled flag");
    pair_excl_a: assert property (@(posedge aclk) disable iff (!aresetn)
        r.cfg.dz_en[0] |-> !(r.outq[0] && r.outq[1]))
        else $error("pair outputs high together");
    indep_out_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (!r.cfg.dz_en[1] && !$past(r.cfg.dz_en[1])) |-> r.outq[3] == $past(lvl[3]))
        else $error("independent output mismatch");
    tick_div_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.tick[0] && r.pre[0] == 8'h01 && r.div[0] == 3'h1 && $stable(r.pre[0])) |=>
        !r.tick[0] ##1 !r.tick[0] ##1 !r.tick[0])
        else $error("tick spacing wrong");
    wr_resp_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.aw_h && r.w_h && !r.bvalid) |=> s_axi_bvalid)
        else $error("write not answered");
    pair_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.cfg.dz_en[0] && $past(r.cfg.dz_en[0]) && !$past(lvl[0])) |-> !r.outq[0])
        else $error("pair output not from timer 0");
    pair3_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (r.cfg.dz_en[3] && $past(r.cfg.dz_en[3]) && $past(lvl[6])) |-> !r.outq[7])
        else $error("pair 6/7 not from timer 6");

    cov_irq_c: cover property (@(posedge aclk) disable iff (!aresetn) irq);
    cov_pair_c: cover property (@(posedge aclk) disable iff (!aresetn)
        r.cfg.dz_en[0] && r.outq[1]);
    cov_clr_c: cover property (@(posedge aclk) disable iff (!aresetn)
        $fell(r.stat[0]));
endmodule

//--- core/dgpg_pkg.sv
// Package: register map, field layouts and reset values of the pulse generator
package dgpg_pkg;
    localparam int CH_N = 8;
    localparam int AW = 8;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE = 8'h04;
    localparam logic [7:0] OFF_DZEN = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_MASK = 8'h10;
    localparam logic [7:0] OFF_PRE = 8'h14;
    localparam logic [7:0] OFF_OUT = 8'h18;
    localparam logic [7:0] OFF_PER0 = 8'h20;
    localparam logic [7:0] OFF_CMP0 = 8'h40;
    localparam logic [7:0] OFF_DT0 = 8'h60;
    // Prescaler word layout: per generator an 8-bit value; the 3-bit divider codes sit in the OUT word
    localparam int PRE_W = 8;
    localparam int DIV_W = 3;
    localparam logic [2:0] DIV_MAX = 3'h4;
    localparam logic [15:0] PER_RST = 16'hffff;
    localparam logic [15:0] CMP_RST = 16'h0000;
    localparam logic [7:0] DT_RST = 8'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] run;
        logic [7:0] autoreload;
        logic [3:0] dz_en;
        logic [7:0] mask;
    } dgpg_cfg_s;
endpackage

//--- core/dgpg_timer.sv
// One timer: prescaled down counter with double-buffered period and compare
`timescale 1ns/10ps
module dgpg_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic run,
    input wire logic autoreload,
    input wire logic tick,
    input wire logic [15:0] period_buf,
    input wire logic [15:0] cmp_buf,
    output logic zero_pulse,
    output logic level
);
    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] cmp;
        logic stopped;
        logic lvl;
        logic zp;
        logic armed;
    } dgpg_tmr_s;

    dgpg_tmr_s r;
    dgpg_tmr_s next_r;

    always_comb begin
        next_r = r;
        next_r.zp = 1'b0;
        if (!run) begin
            next_r.armed = 1'b0;
            next_r.stopped = 1'b0;
            next_r.lvl = 1'b0;
        end else if (!r.armed) begin
            // Start loads the buffers, so the first period is the programmed one
            next_r.armed = 1'b1;
            next_r.cnt = period_buf;
            next_r.cmp = cmp_buf;
            next_r.lvl = 1'b0;
        end else if (tick && !r.stopped) begin
            if (r.cnt == 16'h0000) begin
                next_r.zp = 1'b1;
                if (autoreload) begin
                    next_r.cnt = period_buf;
                    next_r.cmp = cmp_buf;
                    next_r.lvl = 1'b0;
                end else begin
                    next_r.stopped = 1'b1;
                end
            end else begin
                next_r.cnt = r.cnt - 16'h0001;
                if (r.cnt - 16'h0001 == r.cmp) begin
                    next_r.lvl = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign zero_pulse = r.zp;
    assign level = r.lvl;

    stop_holds_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && r.stopped) |=> !r.zp)
        else $error("one-shot timer fired again");
    reload_low_a: assert property (@(posedge aclk) disable iff (!aresetn)
        (run && autoreload && r.zp) |-> !r.lvl)
        else $error("level not low after reload");
endmodule

//--- test/dgpg_load.sv
// Partner model: load on the pulse outputs, counting rising edges and paired overlaps
`timescale 1ns/10ps
module dgpg_load (
    input wire logic aclk,
    input wire logic clr,
    input wire logic [7:0] drive,
    output logic [7:0][7:0] rises,
    output logic [7:0] overlaps
);
    // ----------------------------------------
    // Edge and shoot-through counters
    // ----------------------------------------
    logic [7:0] prev;
    always_ff @(posedge aclk) begin
        prev <= drive;
        for (int i = 0; i < 8; i++) begin
            if (clr) rises[i] <= 8'h00;
            else if (drive[i] && !prev[i]) rises[i] <= rises[i] + 8'h01;
        end
        // Both legs of a pair high at once would short a half bridge
        if (clr) overlaps <= 8'h00;
        else if (|(drive & (drive >> 1) & 8'h55)) overlaps <= overlaps + 8'h01;
    end
endmodule

//--- test/dgpg_tb.sv
// Testbench: registers, timing, interrupt and dead zone of the pulse generator
`timescale 1ns/10ps
module dgpg_tb;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic clr = 1'b1;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rdata, rdv;
    logic [7:0] outs, overlaps;
    logic [7:0][7:0] rises;
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    dgpg_top DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pulse_outputs_zero_to_seven(outs), .irq(irq));
    dgpg_load load (.aclk(aclk), .clr(clr), .drive(outs), .rises(rises), .overlaps(overlaps));

    always #12.5 aclk = ~aclk;
    // Whole run needs a few thousand cycles
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 50000) begin
            num_errors++;
            summarize();
        end
    end

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    task automatic do_reset();
        @(posedge aclk);
        aresetn <= 1'b0;
        clr <= 1'b1;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        clr <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                resp = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                rdv = rdata;
                resp = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // Cycle stamp of the first clock at which output ch shows level v
    task automatic lvl(input int ch, input logic v, output int t);
        do @(posedge aclk); while (outs[ch] !== v);
        t = cyc;
    endtask

    task automatic rise(input int ch, output int t);
        lvl(ch, 1'b0, t);
        lvl(ch, 1'b1, t);
    endtask

    task automatic setch(input int c, input logic [15:0] p, input logic [15:0] k);
        wr(dgpg_pkg::OFF_PER0 + 8'(c * 4), {16'h0, p});
        wr(dgpg_pkg::OFF_CMP0 + 8'(c * 4), {16'h0, k});
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd(dgpg_pkg::OFF_PER0 + 8'h1c);
        check(rdv, {16'h0, dgpg_pkg::PER_RST}, "period reset");
        rd(dgpg_pkg::OFF_CMP0);
        check(rdv, {16'h0, dgpg_pkg::CMP_RST}, "compare reset");
        rd(dgpg_pkg::OFF_CTRL);
        check(rdv, 32'h0, "run reset");
        wr(dgpg_pkg::OFF_PER0 + 8'h0c, 32'h0000abcd);
        rd(dgpg_pkg::OFF_PER0 + 8'h0c);
        check(rdv, 32'h0000abcd, "period readback");
        // Only the low byte lane is enabled, so the high byte must survive
        wstrb <= 4'h1;
        wr(dgpg_pkg::OFF_PER0 + 8'h0c, 32'h00001234);
        wstrb <= 4'hf;
        rd(dgpg_pkg::OFF_PER0 + 8'h0c);
        check(rdv, 32'h0000ab34, "byte strobe write");
        rd(8'h1c);
        check({30'h0, resp}, {30'h0, dgpg_pkg::RESP_SLVERR}, "unmapped read");
        wr(8'hfc, 32'h1);
        check({30'h0, resp}, {30'h0, dgpg_pkg::RESP_SLVERR}, "unmapped write");
        $display("test regs done");
    endtask

    task automatic t_auto();
        int a, b, c, d, e;
        do_reset();
        setch(0, 16'h0013, 16'h0004);
        wr(dgpg_pkg::OFF_MODE, 32'h1);
        wr(dgpg_pkg::OFF_CTRL, 32'h1);
        rise(0, a);
        lvl(0, 1'b0, b);
        rise(0, c);
        check(b - a, 5, "high width");
        check(c - b, 15, "low width");
        check(c - a, 20, "period");
        lvl(0, 1'b0, b);
        wr(dgpg_pkg::OFF_CMP0, 32'h000a);
        lvl(0, 1'b1, c);
        lvl(0, 1'b0, d);
        lvl(0, 1'b1, e);
        check(c - b, 15, "old compare kept");
        check(d - c, 5, "old high width");
        check(e - d, 9, "new compare at zero");
        rd(dgpg_pkg::OFF_STAT);
        check({31'h0, rdv[0]}, 32'h1, "flag at zero");
        $display("test auto done");
    endtask

    task automatic t_div();
        int a, b;
        logic [7:0] pre;
        logic [2:0] dv;
        for (int i = 0; i < 6; i++) begin
            pre = (i == 5) ? 8'hff : 8'h01;
            dv = (i == 5) ? 3'h0 : 3'(i);
            do_reset();
            wr(dgpg_pkg::OFF_PRE, {24'h0, pre});
            wr(dgpg_pkg::OFF_OUT, {29'h0, dv});
            setch(0, 16'h0003, 16'h0001);
            wr(dgpg_pkg::OFF_MODE, 32'h1);
            wr(dgpg_pkg::OFF_CTRL, 32'h1);
            rise(0, a);
            rise(0, a);
            rise(0, b);
            check(b - a, 4 * (int'(pre) + 1) * (1 << dv), "scaled period");
        end
        $display("test divider done");
    endtask

    task automatic t_oneshot();
        do_reset();
        for (int c = 0; c < 8; c++) setch(c, 16'h0005, 16'h0002);
        wr(dgpg_pkg::OFF_MASK, 32'hfd);
        wr(dgpg_pkg::OFF_CTRL, 32'hff);
        repeat (40) @(posedge aclk);
        rd(dgpg_pkg::OFF_STAT);
        check(rdv[7:0], 8'hff, "all flags");
        for (int c = 0; c < 8; c++) check(rises[c], 8'h01, "one pulse");
        wr(dgpg_pkg::OFF_STAT, 32'h02);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h1, "unmasked others");
        wr(dgpg_pkg::OFF_MASK, 32'h02);
        repeat (2) @(posedge aclk);
        check({31'h0, irq}, 32'h0, "cleared flag masked in");
        rd(dgpg_pkg::OFF_STAT);
        check(rdv[7:0], 8'hfd, "one flag cleared");
        repeat (40) @(posedge aclk);
        rd(dgpg_pkg::OFF_STAT);
        check(rdv[7:0], 8'hfd, "no second request");
        $display("test oneshot done");
    endtask

    task automatic t_pairs();
        int a, b, c, d;
        do_reset();
        wr(dgpg_pkg::OFF_DZEN, 32'hf);
        for (int g = 0; g < 4; g++) begin
            setch(2 * g, 16'h0013, 16'h0009);
            wr(dgpg_pkg::OFF_DT0 + 8'(g * 4), 32'h3);
        end
        wr(dgpg_pkg::OFF_MODE, 32'h55);
        wr(dgpg_pkg::OFF_CTRL, 32'h55);
        for (int g = 0; g < 4; g++) begin
            rise(2 * g, a);
            lvl(2 * g, 1'b0, b);
            lvl(2 * g + 1, 1'b1, c);
            lvl(2 * g + 1, 1'b0, d);
            check(b - a, 7, "pair high width");
            check(c - b, 3, "dead gap");
            check(d - c, 7, "complement width");
        end
        check(overlaps, 8'h00, "no overlap");
        $display("test pairs done");
    endtask

    initial begin
        do_reset();
        t_regs();
        t_auto();
        t_div();
        t_oneshot();
        t_pairs();
        summarize();
    end
endmodule
